//--- pkg/ccg_pkg.sv
package ccg_pkg;
  // clock rate and derived timing
  localparam int CLK_HZ    = 25_000_000;
  localparam int CLK_MHZ   = CLK_HZ / 1_000_000;
  localparam int MASK_US   = 2500;  // pll output masked at wake-up code 0
  localparam int WAKE1_US  = 500;   // wake-up time before the ramp at code 1
  localparam int RAMP_US   = 2000;  // ramp from start frequency to target
  localparam int MASK_CYC  = MASK_US * CLK_MHZ;
  localparam int WAKE1_CYC = WAKE1_US * CLK_MHZ;
  localparam int RAMP_CYC  = RAMP_US * CLK_MHZ;
  localparam int LS_HZ     = 32768;
  localparam int LS_DIV    = (CLK_HZ + LS_HZ / 2) / LS_HZ;
  localparam int RAMP_MHZ  = 1;     // ramp start frequency
  localparam int RAMP_DIV0 = CLK_MHZ / RAMP_MHZ;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 17;
  localparam int DIV_W  = 10;
  localparam int IRQ_W  = 3;
  localparam int GATE_W = 8;
  localparam int OUTD_W = 3;
  typedef logic [CNT_W-1:0] ccg_cnt_t;
  typedef logic [DIV_W-1:0] ccg_div_t;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CLOCK_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LOWSPEED_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_WAKEUP_TIME   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CLK_STATUS    = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_BACKUP_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR     = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE    = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_BLOCK_GATE    = 8'h20;
  localparam logic [ADDR_W-1:0] REG_HS_OUT_CTRL   = 8'h24;

  // field positions
  localparam int CTRL_OSC_EN  = 0;
  localparam int CTRL_SEL     = 1;
  localparam int LSM_MODE_MSB = 1;
  localparam int LSM_REQ      = 2;
  localparam int ST_RUN       = 0;
  localparam int ST_RAMP      = 1;
  localparam int ST_MASK      = 2;
  localparam int ST_SEL       = 3;
  localparam int IRQ_HS_READY = 0;
  localparam int IRQ_LS_DONE  = 1;
  localparam int IRQ_LS_FAULT = 2;
  localparam int HSO_EN       = 3;

  // wake-up codes and axi answers
  localparam logic [7:0] WAKE_CODE_MASK = 8'h00;
  localparam logic [7:0] WAKE_CODE_RAMP = 8'h01;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    LS_RC   = 2'b00,
    LS_XTAL = 2'b01,
    LS_RSV  = 2'b10,
    LS_EXT  = 2'b11
  } ccg_lsmode_e;

  typedef enum logic [1:0] {
    HS_OFF  = 2'b00,
    HS_WAKE = 2'b01,
    HS_RAMP = 2'b10,
    HS_RUN  = 2'b11
  } ccg_hs_e;

  // clock enable pulses handed to the rest of the chip
  typedef struct packed {
    logic sys;
    logic hs;
    logic ls;
  } ccg_clken_s;
endpackage

//--- verilog/ccg_tick_div.sv
module ccg_tick_div (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // divider control
  input  wire logic              en,
  input  wire ccg_pkg::ccg_div_t div,
  // one-cycle enable pulse
  output logic                   tick
);
  typedef struct packed {
    ccg_pkg::ccg_div_t cnt;
    logic              tick;
  } ccg_div_s;

  ccg_div_s s;
  ccg_div_s next_s;

  // count up to div-1, pulse at the wrap
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!en || div == '0) begin
      next_s.cnt = '0;
    end else if (s.cnt >= div - ccg_pkg::ccg_div_t'(1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + ccg_pkg::ccg_div_t'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

//--- verilog/ccg_clk_switch.sv
module ccg_clk_switch (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // source pulses and request
  input  wire logic           ls_tick,
  input  wire logic           hs_tick,
  input  wire logic           hs_on,
  input  wire logic           req_sel,
  // selected source and enables
  output logic                cur_sel,
  output ccg_pkg::ccg_clken_s clk_en
);
  typedef struct packed {
    logic                cur;
    ccg_pkg::ccg_clken_s en;
  } ccg_sw_s;

  ccg_sw_s s;
  ccg_sw_s next_s;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // source changes only on a low-speed edge, and only to an enabled source
  always_comb begin
    next_s = s;
    next_s.en.ls  = ls_tick;
    next_s.en.hs  = hs_tick;
    next_s.en.sys = s.cur ? hs_tick : ls_tick;
    if (ls_tick) begin
      next_s.cur = req_sel & hs_on;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cur_sel = s.cur;
  assign clk_en  = s.en;

  sw_aligned_a: assert property ($changed(s.cur) |-> $past(ls_tick)
      && (!s.cur || $past(hs_on)))
    else $error("source switched off a low-speed edge or to a disabled source");
  hs_stop_a: assert property (s.cur && !hs_tick |=> !clk_en.sys)
    else $error("system clock ran while high-speed source gave no pulse");
endmodule

//--- verilog/ccg_clock_ctrl.sv
module ccg_clock_ctrl #(
  parameter int MASK_CYC  = ccg_pkg::MASK_CYC,
  parameter int WAKE1_CYC = ccg_pkg::WAKE1_CYC,
  parameter int RAMP_CYC  = ccg_pkg::RAMP_CYC
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address and data
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [ccg_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [ccg_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // axi4-lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // axi4-lite read
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [ccg_pkg::ADDR_W-1:0]  s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [ccg_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // power management and oscillator monitor
  input  wire logic                        halt_h_release,
  input  wire logic                        ls_osc_fault_in,
  // clock outputs
  output ccg_pkg::ccg_clken_s              clk_en,
  output logic                             sys_clk_select_cur,
  output logic [1:0]                       ls_src_sel,
  output logic [ccg_pkg::GATE_W-1:0]       blk_clk_gate,
  output logic                             hs_clock_out_pin,
  // interrupt
  output logic                             irq
);
  localparam ccg_pkg::ccg_cnt_t RAMP_STEP =
    ccg_pkg::ccg_cnt_t'(RAMP_CYC / (ccg_pkg::RAMP_DIV0 - 1));
  localparam ccg_pkg::ccg_cnt_t CNT_ONE = ccg_pkg::ccg_cnt_t'(1);
  localparam ccg_pkg::ccg_div_t DIV_ONE = ccg_pkg::ccg_div_t'(1);
  localparam ccg_pkg::ccg_div_t DIV_TWO = ccg_pkg::ccg_div_t'(2);
  localparam int AST_RAMP_WIN = 27;
  localparam int AST_LS_WIN   = 764;

  typedef struct packed {
    logic                       awv;
    logic                       awrdy;
    logic [ccg_pkg::ADDR_W-1:0] awaddr;
    logic                       wv;
    logic                       wrdy;
    logic [ccg_pkg::DATA_W-1:0] wdata;
    logic                       wlo;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arrdy;
    logic                       rvalid;
    logic [ccg_pkg::DATA_W-1:0] rdata;
    logic [1:0]                 rresp;
    logic                       osc_en;
    logic                       sel;
    ccg_pkg::ccg_lsmode_e       ls_mode;
    ccg_pkg::ccg_lsmode_e       ls_act;
    logic                       ls_req;
    logic                       fault;
    logic [7:0]                 wake_code;
    ccg_pkg::ccg_hs_e           hs_st;
    logic                       ramp;
    ccg_pkg::ccg_cnt_t          cnt;
    ccg_pkg::ccg_div_t          rdiv;
    ccg_pkg::ccg_cnt_t          step;
    logic [ccg_pkg::IRQ_W-1:0]  irq_st;
    logic [ccg_pkg::IRQ_W-1:0]  irq_en;
    logic                       irq;
    logic [ccg_pkg::GATE_W-1:0] gate;
    logic                       hso_en;
    logic [ccg_pkg::OUTD_W-1:0] hso_div;
    logic [7:0]                 hso_cnt;
    logic                       hso_pin;
  } ccg_top_s;

  ccg_top_s                  s;
  ccg_top_s                  next_s;
  logic [ccg_pkg::IRQ_W-1:0] ev;
  logic                      wr_go;
  logic                      ls_tick;
  logic                      hs_tick;
  logic                      hs_run;
  ccg_pkg::ccg_div_t         hs_div;
  logic                      cur_sel;
  ccg_pkg::ccg_clken_s       sw_en;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // low-speed source, free running
  ccg_tick_div u_ls_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (1'b1),
    .div     (ccg_pkg::ccg_div_t'(ccg_pkg::LS_DIV)),
    .tick    (ls_tick)
  );

  // high-speed source, masked while waking, slowed while ramping
  assign hs_run = (s.hs_st == ccg_pkg::HS_RUN) || (s.hs_st == ccg_pkg::HS_RAMP);
  assign hs_div = (s.hs_st == ccg_pkg::HS_RUN) ? DIV_ONE : s.rdiv;

  ccg_tick_div u_hs_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (hs_run),
    .div     (hs_div),
    .tick    (hs_tick)
  );

  // glitch-free system clock selection
  ccg_clk_switch u_switch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ls_tick (ls_tick),
    .hs_tick (hs_tick),
    .hs_on   (s.osc_en),
    .req_sel (s.sel),
    .cur_sel (cur_sel),
    .clk_en  (sw_en)
  );

  assign wr_go = s.awv & s.wv & ~s.bvalid;

  // next state: bus slave, wake-up sequencer, low-speed switch, interrupts
  always_comb begin
    next_s = s;
    ev     = '0;
    // capture address and data in either order
    if (s_axi_awvalid && s.awrdy) begin
      next_s.awv    = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wrdy) begin
      next_s.wv    = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wlo   = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // low-speed switch request handled on a low-speed edge
    if (s.ls_req && ls_tick) begin
      next_s.ls_req = 1'b0;
      if (s.ls_mode != ccg_pkg::LS_RC && ls_osc_fault_in) begin
        ev[ccg_pkg::IRQ_LS_FAULT] = 1'b1;
      end else begin
        next_s.ls_act = (s.ls_mode == ccg_pkg::LS_RSV) ? ccg_pkg::LS_RC : s.ls_mode;
        ev[ccg_pkg::IRQ_LS_DONE] = 1'b1;
      end
    end
    // high-speed wake-up sequencer
    case (s.hs_st)
      ccg_pkg::HS_OFF: begin
        if (s.osc_en) begin
          next_s.hs_st = ccg_pkg::HS_WAKE;
          next_s.ramp  = (s.wake_code == ccg_pkg::WAKE_CODE_RAMP);
          next_s.cnt   = (s.wake_code == ccg_pkg::WAKE_CODE_MASK) ?
                         ccg_pkg::ccg_cnt_t'(MASK_CYC) :
                         ccg_pkg::ccg_cnt_t'(WAKE1_CYC);
        end
      end
      ccg_pkg::HS_WAKE: begin
        if (s.cnt <= CNT_ONE) begin
          if (s.ramp) begin
            next_s.hs_st = ccg_pkg::HS_RAMP;
            next_s.rdiv  = ccg_pkg::ccg_div_t'(ccg_pkg::RAMP_DIV0);
            next_s.step  = RAMP_STEP;
          end else begin
            next_s.hs_st = ccg_pkg::HS_RUN;
            ev[ccg_pkg::IRQ_HS_READY] = 1'b1;
          end
        end else begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      ccg_pkg::HS_RAMP: begin
        if (s.step <= CNT_ONE) begin
          next_s.step = RAMP_STEP;
          if (s.rdiv <= DIV_TWO) begin
            next_s.hs_st = ccg_pkg::HS_RUN;
            ev[ccg_pkg::IRQ_HS_READY] = 1'b1;
          end else begin
            next_s.rdiv = s.rdiv - DIV_ONE;
          end
        end else begin
          next_s.step = s.step - CNT_ONE;
        end
      end
      ccg_pkg::HS_RUN: begin
        next_s.hs_st = ccg_pkg::HS_RUN;
      end
      default: begin
        next_s.hs_st = ccg_pkg::HS_OFF;
      end
    endcase
    if (!s.osc_en) begin
      next_s.hs_st = ccg_pkg::HS_OFF;
    end
    // register write once both address and data are held
    if (wr_go) begin
      next_s.awv   = 1'b0;
      next_s.wv    = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = ccg_pkg::RESP_OKAY;
      case (s.awaddr)
        ccg_pkg::REG_CLOCK_CTRL: if (s.wlo) begin
          next_s.osc_en = s.wdata[ccg_pkg::CTRL_OSC_EN];
          next_s.sel    = s.wdata[ccg_pkg::CTRL_SEL];
        end
        ccg_pkg::REG_LOWSPEED_MODE: if (s.wlo) begin
          next_s.ls_mode = ccg_pkg::ccg_lsmode_e'(s.wdata[ccg_pkg::LSM_MODE_MSB:0]);
          if (s.wdata[ccg_pkg::LSM_REQ]) begin
            next_s.ls_req = 1'b1;
          end
          if (s.wdata[ccg_pkg::LSM_MODE_MSB:0] == ccg_pkg::LS_RC) begin
            next_s.fault = 1'b0;
          end
        end
        ccg_pkg::REG_WAKEUP_TIME: if (s.wlo) begin
          next_s.wake_code = s.wdata[7:0];
        end
        ccg_pkg::REG_IRQ_CLEAR: if (s.wlo) begin
          next_s.irq_st = s.irq_st & ~s.wdata[ccg_pkg::IRQ_W-1:0];
        end
        ccg_pkg::REG_IRQ_ENABLE: if (s.wlo) begin
          next_s.irq_en = s.wdata[ccg_pkg::IRQ_W-1:0];
        end
        ccg_pkg::REG_BLOCK_GATE: if (s.wlo) begin
          next_s.gate = s.wdata[ccg_pkg::GATE_W-1:0];
        end
        ccg_pkg::REG_HS_OUT_CTRL: if (s.wlo) begin
          next_s.hso_div = s.wdata[ccg_pkg::OUTD_W-1:0];
          next_s.hso_en  = s.wdata[ccg_pkg::HSO_EN];
        end
        ccg_pkg::REG_CLK_STATUS, ccg_pkg::REG_BACKUP_STATUS,
        ccg_pkg::REG_IRQ_STATUS: begin
          next_s.bresp = ccg_pkg::RESP_OKAY;  // read-only, write ignored
        end
        default: begin
          next_s.bresp = ccg_pkg::RESP_SLVERR;
        end
      endcase
    end
    // leaving high-speed halt overrides a clock control write in the same cycle
    if (halt_h_release) begin
      next_s.osc_en = 1'b1;
      next_s.sel    = 1'b1;
    end
    // hardware sets win over software clears
    next_s.fault  = next_s.fault | ev[ccg_pkg::IRQ_LS_FAULT];
    next_s.irq_st = next_s.irq_st | ev;
    next_s.awrdy  = !next_s.awv;
    next_s.wrdy   = !next_s.wv;
    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arrdy  = 1'b1;
    end
    if (s_axi_arvalid && s.arrdy) begin
      next_s.arrdy  = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata  = '0;
      next_s.rresp  = ccg_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ccg_pkg::REG_CLOCK_CTRL: begin
          next_s.rdata[ccg_pkg::CTRL_OSC_EN] = s.osc_en;
          next_s.rdata[ccg_pkg::CTRL_SEL]    = s.sel;
        end
        ccg_pkg::REG_LOWSPEED_MODE: begin
          next_s.rdata[ccg_pkg::LSM_MODE_MSB:0] = s.ls_mode;
          next_s.rdata[ccg_pkg::LSM_REQ]        = s.ls_req;
        end
        ccg_pkg::REG_WAKEUP_TIME: next_s.rdata[7:0] = s.wake_code;
        ccg_pkg::REG_CLK_STATUS: begin
          next_s.rdata[ccg_pkg::ST_RUN]  = (s.hs_st == ccg_pkg::HS_RUN);
          next_s.rdata[ccg_pkg::ST_RAMP] = (s.hs_st == ccg_pkg::HS_RAMP);
          next_s.rdata[ccg_pkg::ST_MASK] = (s.hs_st == ccg_pkg::HS_WAKE);
          next_s.rdata[ccg_pkg::ST_SEL]  = cur_sel;
        end
        ccg_pkg::REG_BACKUP_STATUS: next_s.rdata[0] = s.fault;
        ccg_pkg::REG_IRQ_STATUS: next_s.rdata[ccg_pkg::IRQ_W-1:0] = s.irq_st;
        ccg_pkg::REG_IRQ_CLEAR: next_s.rdata = '0;
        ccg_pkg::REG_IRQ_ENABLE: next_s.rdata[ccg_pkg::IRQ_W-1:0] = s.irq_en;
        ccg_pkg::REG_BLOCK_GATE: next_s.rdata[ccg_pkg::GATE_W-1:0] = s.gate;
        ccg_pkg::REG_HS_OUT_CTRL: begin
          next_s.rdata[ccg_pkg::OUTD_W-1:0] = s.hso_div;
          next_s.rdata[ccg_pkg::HSO_EN]     = s.hso_en;
        end
        default: next_s.rresp = ccg_pkg::RESP_SLVERR;
      endcase
    end
    // high-speed output pin toggles every 2^div high-speed pulses
    if (!s.hso_en) begin
      next_s.hso_cnt = '0;
      next_s.hso_pin = 1'b0;
    end else if (hs_tick) begin
      if (s.hso_cnt >= (8'h01 << s.hso_div) - 8'h01) begin
        next_s.hso_cnt = '0;
        next_s.hso_pin = !s.hso_pin;
      end else begin
        next_s.hso_cnt = s.hso_cnt + 8'h01;
      end
    end
    next_s.irq = |(next_s.irq_st & next_s.irq_en);
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s       <= '0;
      s.awrdy <= 1'b1;
      s.wrdy  <= 1'b1;
      s.arrdy <= 1'b1;
      s.sel   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign s_axi_awready      = s.awrdy;
  assign s_axi_wready       = s.wrdy;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = s.arrdy;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign clk_en             = sw_en;
  assign sys_clk_select_cur = cur_sel;
  assign ls_src_sel         = s.ls_act;
  assign blk_clk_gate       = s.gate;
  assign hs_clock_out_pin   = s.hso_pin;
  assign irq                = s.irq;

  // checks
  mask_load_a: assert property (s.hs_st == ccg_pkg::HS_OFF && s.osc_en
      && s.wake_code == ccg_pkg::WAKE_CODE_MASK
      |=> s.hs_st == ccg_pkg::HS_WAKE && s.cnt == ccg_pkg::ccg_cnt_t'(MASK_CYC))
    else $error("mask count not loaded on enable");
  mask_quiet_a: assert property ($past(s.hs_st) == ccg_pkg::HS_WAKE |-> !hs_tick)
    else $error("high-speed pulse during mask");
  mask_end_a: assert property (s.hs_st == ccg_pkg::HS_WAKE && s.cnt == CNT_ONE
      && !s.ramp && s.osc_en
      |=> s.hs_st == ccg_pkg::HS_RUN && s.irq_st[ccg_pkg::IRQ_HS_READY])
    else $error("mask did not end on time");
  ramp_start_a: assert property (s.hs_st == ccg_pkg::HS_RAMP
      && $past(s.hs_st) == ccg_pkg::HS_WAKE |-> s.rdiv == ccg_pkg::RAMP_DIV0)
    else $error("ramp did not start at the slow rate");
  ramp_tick_a: assert property (s.hs_st == ccg_pkg::HS_RAMP && s.osc_en
      |-> ##[1:AST_RAMP_WIN] hs_tick)
    else $error("ramping clock gave no pulse");
  reset_sel_a: assert property ($past(!aresetn) |-> !s.sel && !cur_sel)
    else $error("low-speed not selected after reset");
  halt_force_a: assert property (halt_h_release |=> s.osc_en && s.sel)
    else $error("halt release did not force enable and select");
  req_zero_a: assert property (wr_go && s.wlo
      && s.awaddr == ccg_pkg::REG_LOWSPEED_MODE && !s.wdata[ccg_pkg::LSM_REQ]
      && !s.ls_req |=> !s.ls_req)
    else $error("writing zero set the switch request");
  req_clear_a: assert property (s.ls_req && !wr_go
      |-> ##[1:AST_LS_WIN] !s.ls_req)
    else $error("switch request never cleared");
  ls_src_a: assert property (s.ls_req && ls_tick && !ls_osc_fault_in
      && s.ls_mode == ccg_pkg::LS_XTAL |=> ls_src_sel == ccg_pkg::LS_XTAL)
    else $error("crystal source not applied");
endmodule

//--- dv/ccg_clock_ctrl_bench.sv
module ccg_clock_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                aclk = 1'b0, aresetn = 1'b0, halt = 1'b0, fault = 1'b0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, sel_cur, hs_pin, irq;
  logic [7:0]          awaddr = 8'h00, araddr = 8'h00, gate;
  logic [31:0]         wdata = 32'h0, rdata, d;
  logic [3:0]          wstrb = 4'h0;
  logic [1:0]          bresp, rresp, ls_sel, br, rr;
  logic                pin_q;
  ccg_pkg::ccg_clken_s clk_en;
  int                  n_errors = 0, checks_done = 0, hs_cnt = 0, base, n_tog;

  // device under test with shortened wake and ramp counts
  ccg_clock_ctrl #(.MASK_CYC(40), .WAKE1_CYC(20), .RAMP_CYC(240)) i_ccg_clock_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .halt_h_release(halt), .ls_osc_fault_in(fault), .clk_en(clk_en),
    .sys_clk_select_cur(sel_cur), .ls_src_sel(ls_sel), .blk_clk_gate(gate),
    .hs_clock_out_pin(hs_pin), .irq(irq));

  // clock and high-speed pulse counter
  always #20 aclk = ~aclk;
  always @(posedge aclk) if (clk_en.hs === 1'b1) hs_cnt++;

  // compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // axi4-lite write, held until each channel is taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    br = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read into d
  task rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // read until masked field matches, bounded
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 400; i++) begin
      rd(a);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask

  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog
  initial begin
    #(40 * 40000);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(sel_cur, 0);
    chk(ls_sel, 0);
    rd(ccg_pkg::REG_CLOCK_CTRL); chk(d, 0);
    wr(ccg_pkg::REG_LOWSPEED_MODE, 32'h7);
    wr(ccg_pkg::REG_LOWSPEED_MODE, 32'h3);
    rd(ccg_pkg::REG_LOWSPEED_MODE); chk(d[2], 1);
    poll(ccg_pkg::REG_LOWSPEED_MODE, 32'h4, 32'h0);
    chk(ls_sel, 2'b11);
    wr(ccg_pkg::REG_LOWSPEED_MODE, 32'h5);
    poll(ccg_pkg::REG_LOWSPEED_MODE, 32'h4, 32'h0);
    chk(ls_sel, 2'b01);
    // a failed switch keeps the old source and raises the fault flag
    fault <= 1'b1;
    wr(ccg_pkg::REG_LOWSPEED_MODE, 32'h7);
    poll(ccg_pkg::REG_LOWSPEED_MODE, 32'h4, 32'h0);
    rd(ccg_pkg::REG_BACKUP_STATUS); chk(d[0], 1);
    chk(ls_sel, 2'b01);
    fault <= 1'b0;
    wr(ccg_pkg::REG_LOWSPEED_MODE, 32'h0);
    chk(br, ccg_pkg::RESP_OKAY);
    rd(8'hfc); chk(rr, ccg_pkg::RESP_SLVERR);
    // masked wake-up at code zero, ready interrupt
    wr(ccg_pkg::REG_IRQ_ENABLE, 32'h1);
    wr(ccg_pkg::REG_WAKEUP_TIME, 32'h0);
    wr(ccg_pkg::REG_CLOCK_CTRL, 32'h3);
    base = hs_cnt;
    repeat (36) @(posedge aclk);
    chk(hs_cnt - base, 0);
    poll(ccg_pkg::REG_CLK_STATUS, 32'h1, 32'h1);
    // pulses appear two cycles after the mask ends
    repeat (3) @(posedge aclk);
    chk(hs_cnt > base, 1);
    chk(irq, 1);
    wr(ccg_pkg::REG_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    // output pin toggles every fourth high-speed pulse, 3.125 MHz
    wr(ccg_pkg::REG_HS_OUT_CTRL, 32'ha);
    pin_q = hs_pin;
    n_tog = 0;
    repeat (32) begin
      @(posedge aclk);
      if (hs_pin !== pin_q) n_tog++;
      pin_q = hs_pin;
    end
    chk(n_tog, 8);
    // block clock gates follow the register
    wr(ccg_pkg::REG_BLOCK_GATE, 32'ha5);
    chk(gate, 8'ha5);
    poll(ccg_pkg::REG_CLK_STATUS, 32'h8, 32'h8);
    chk(clk_en.sys, 1);
    // halt release forces enable and select
    wr(ccg_pkg::REG_CLOCK_CTRL, 32'h0);
    @(posedge aclk) halt <= 1'b1;
    @(posedge aclk) halt <= 1'b0;
    rd(ccg_pkg::REG_CLOCK_CTRL); chk(d, 32'h3);
    chk(clk_en.sys & sel_cur, 0);
    // ramped wake-up at code one
    wr(ccg_pkg::REG_CLOCK_CTRL, 32'h0);
    wr(ccg_pkg::REG_WAKEUP_TIME, 32'h1);
    wr(ccg_pkg::REG_CLOCK_CTRL, 32'h1);
    poll(ccg_pkg::REG_CLK_STATUS, 32'h2, 32'h2);
    poll(ccg_pkg::REG_CLK_STATUS, 32'h3, 32'h1);
    finish_test();
  end
endmodule
